// >>> verilog/kwd_pkg.sv
// Behaviour
// - count source clock, divide 2^8 to 2^18
// - select field picks one of eight ratios
// - key 10101 disables the watchdog
// - key 01010 enables the watchdog
// - other key resets device after delay
// - key fault flag sticky until software clears
// - key field powers up as enable
// - normal overflow resets device, sets timeout
// - sleep overflow resets pc/sp, sets timeout
// - fault, clear instruction, halt clear count
// - power-on reset sets program counter zero
// - power-on reset sets ports to ones
// - reset flag bits six to one read zero
// - clear instruction and power-up clear powerdown
// - deepest sleep clears and stops the counter
package kwd_pkg;
  localparam logic [7:0] ADR_WDC = 8'h00;
  localparam logic [7:0] ADR_RFC = 8'h04;
  localparam logic [7:0] ADR_IST = 8'h08;
  localparam logic [7:0] ADR_IMK = 8'h0c;
  localparam logic [7:0] ADR_CST = 8'h10;
  localparam logic [7:0] WDC_RESET = 8'h53;
  localparam logic [4:0] KEY_ENABLE = 5'h0a;
  localparam logic [4:0] KEY_DISABLE = 5'h15;
  localparam int KEY_LSB = 3;
  localparam int FLAG_KEY = 0;
  localparam int FLAG_KEEP = 7;
  localparam int ST_TIMEOUT = 0;
  localparam int ST_PDOWN = 1;
  localparam int EV_OVF = 0;
  localparam int EV_KEY = 1;
  localparam int CNT_W = 18;
  localparam int FAULT_DELAY_CYC = 16;
  localparam logic [7:0] PORT_RESET = 8'hff;
  typedef enum logic [1:0] {
    KWD_RUN = 2'b00,
    KWD_WAIT = 2'b01,
    KWD_FIRE = 2'b11
  } kwd_state_t;
  function automatic logic [CNT_W-1:0] kwd_limit(input logic [2:0] sel);
    case (sel)
      3'h0: kwd_limit = 18'h000ff;
      3'h1: kwd_limit = 18'h003ff;
      3'h2: kwd_limit = 18'h00fff;
      3'h3: kwd_limit = 18'h03fff;
      3'h4: kwd_limit = 18'h07fff;
      3'h5: kwd_limit = 18'h0ffff;
      3'h6: kwd_limit = 18'h1ffff;
      default: kwd_limit = 18'h3ffff;
    endcase
  endfunction
endpackage

// >>> verilog/kwd_tick_if.sv
`timescale 1ns/1ps
interface kwd_tick_if;
  logic tick;
  modport src (output tick);
  modport dst (input tick);
endinterface

// >>> verilog/kwd_src_sync.sv
`timescale 1ns/1ps
// samples the rc oscillator through two flops, emits one pulse per rising edge
module kwd_src_sync (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic rc_clk,
  kwd_tick_if.src tk
);
  import kwd_pkg::*;
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic tick;
  } kwd_sync_t;
  kwd_sync_t r, next_r;
  always_comb begin
    next_r = r;
    next_r.s1 = rc_clk;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    next_r.tick = r.s2 & ~r.s3;
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
  assign tk.tick = r.tick;
endmodule

// >>> verilog/kwd_top.sv
// The Wishbone interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module kwd_top (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic rc_clk,
  input wire logic clear_watchdog_instruction,
  input wire logic halt,
  input wire logic sleep_mode,
  input wire logic deep_sleep,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic dev_reset,
  output logic pc_sp_reset,
  output logic [7:0] port_init,
  output logic irq
);
  import kwd_pkg::*;
  kwd_tick_if tk ();
  kwd_src_sync u_sync (
    .mclk(mclk),
    .reset_n(reset_n),
    .rc_clk(rc_clk),
    .tk(tk)
  );
  typedef struct packed {
    logic [7:0] wdc;
    logic key_flag;
    logic keep;
    logic timeout;
    logic pdown;
    logic [1:0] ist;
    logic [1:0] imk;
    logic [CNT_W-1:0] cnt;
    kwd_state_t st;
    logic [7:0] dly;
    logic dev_reset;
    logic pc_sp_reset;
    logic [7:0] port_init;
    logic ack;
    logic [31:0] dat;
    logic irq;
    logic [1:0] pend;
  } kwd_top_t;
  kwd_top_t r, next_r;
  logic [4:0] key;
  logic en;
  logic ovf;
  logic bus_req;
  logic wr;
  logic rd;
  always_comb begin
    key = r.wdc[7:KEY_LSB];
    // any key other than the enable pattern, the disable one included, stops counting
    en = (key == KEY_ENABLE);
    bus_req = wb_cyc_i & wb_stb_i & ~r.ack;
    wr = bus_req & wb_we_i & wb_sel_i[0];
    rd = bus_req & ~wb_we_i;
    ovf = en & ~deep_sleep & tk.tick & (r.cnt == kwd_limit(r.wdc[2:0]));
    next_r = r;
    next_r.dev_reset = 1'b0;
    next_r.pc_sp_reset = 1'b0;
    next_r.ack = bus_req;
    next_r.pend = 2'b00;
    // counter: key 10101 leaves it frozen
    if (deep_sleep || clear_watchdog_instruction || halt || r.st != KWD_RUN) begin
      next_r.cnt = '0;
    end else if (en && tk.tick) begin
      if (ovf) begin
        next_r.cnt = '0;
      end else begin
        next_r.cnt = r.cnt + 1'b1;
      end
    end
    if (halt) begin
      next_r.pdown = 1'b1;
      next_r.timeout = 1'b0;
    end
    if (clear_watchdog_instruction) begin
      next_r.pdown = 1'b0;
    end
    if (ovf) begin
      next_r.timeout = 1'b1;
      next_r.pend[EV_OVF] = 1'b1;
      if (sleep_mode) begin
        next_r.pc_sp_reset = 1'b1;
      end else begin
        next_r.dev_reset = 1'b1;
      end
    end
    // key fault: a delayed full reset, with the key returned to power-on value in the same cycle
    case (r.st)
      KWD_RUN: begin
        if (key != KEY_ENABLE && key != KEY_DISABLE) begin
          next_r.st = KWD_WAIT;
          next_r.dly = 8'(FAULT_DELAY_CYC - 1);
        end
      end
      KWD_WAIT: begin
        if (r.dly == 8'h00) begin
          next_r.st = KWD_FIRE;
        end else begin
          next_r.dly = r.dly - 8'h01;
        end
      end
      KWD_FIRE: begin
        next_r.dev_reset = 1'b1;
        next_r.key_flag = 1'b1;
        next_r.pend[EV_KEY] = 1'b1;
        next_r.wdc = WDC_RESET;
        next_r.st = KWD_RUN;
      end
      default: next_r.st = KWD_RUN;
    endcase
    if (wr) begin
      case (wb_adr_i)
        ADR_WDC: begin
          if (r.st == KWD_RUN) begin
            next_r.wdc = wb_dat_i[7:0];
          end
        end
        ADR_RFC: begin
          next_r.keep = wb_dat_i[FLAG_KEEP];
          // only software clears; a fault firing now keeps it set
          if (!wb_dat_i[FLAG_KEY] && r.st != KWD_FIRE) begin
            next_r.key_flag = 1'b0;
          end
        end
        ADR_IMK: next_r.imk = wb_dat_i[1:0];
        default: ;
      endcase
    end
    next_r.dat = 32'h0;
    if (rd) begin
      case (wb_adr_i)
        ADR_WDC: next_r.dat = {24'h0, r.wdc};
        ADR_RFC: next_r.dat = {24'h0, r.keep, 6'h00, r.key_flag};
        ADR_IST: begin
          next_r.dat = {30'h0, r.ist};
          next_r.ist = 2'b00;
        end
        ADR_IMK: next_r.dat = {30'h0, r.imk};
        ADR_CST: next_r.dat = {30'h0, r.pdown, r.timeout};
        default: next_r.dat = 32'h0;
      endcase
    end
    // new events win over the read clear
    next_r.ist = next_r.ist | next_r.pend;
    next_r.irq = |(next_r.ist & next_r.imk);
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '0;
      r.wdc <= WDC_RESET;
      r.st <= KWD_RUN;
      r.port_init <= PORT_RESET;
      r.dev_reset <= 1'b1;
    end else begin
      r <= next_r;
    end
  end
  assign wb_dat_o = r.dat;
  assign wb_ack_o = r.ack;
  assign dev_reset = r.dev_reset;
  assign pc_sp_reset = r.pc_sp_reset;
  assign port_init = r.port_init;
  assign irq = r.irq;

  ovf_clears_a: assert property (@(posedge mclk) disable iff (!reset_n)
    ovf |=> (r.cnt == '0) && r.timeout) else $error("overflow did not clear count");
  ovf_full_a: assert property (@(posedge mclk) disable iff (!reset_n)
    ovf && !sleep_mode |=> dev_reset && !pc_sp_reset) else $error("normal overflow wrong reset");
  ovf_sleep_a: assert property (@(posedge mclk) disable iff (!reset_n)
    ovf && sleep_mode |=> pc_sp_reset && !dev_reset) else $error("sleep overflow wrong reset");
  clr_count_a: assert property (@(posedge mclk) disable iff (!reset_n)
    clear_watchdog_instruction || halt || deep_sleep |=> r.cnt == '0) else $error("count not cleared");
  disabled_hold_a: assert property (@(posedge mclk) disable iff (!reset_n)
    key == KEY_DISABLE |-> !ovf) else $error("overflow while disabled");
  fault_delay_a: assert property (@(posedge mclk) disable iff (!reset_n)
    r.st == KWD_RUN && key != KEY_ENABLE && key != KEY_DISABLE |=> !dev_reset [*8] ##10 dev_reset)
    else $error("fault reset timing wrong");
  flag_sticky_a: assert property (@(posedge mclk) disable iff (!reset_n)
    r.key_flag && !(wr && wb_adr_i == ADR_RFC) |=> r.key_flag) else $error("key flag lost");
  pd_clear_a: assert property (@(posedge mclk) disable iff (!reset_n)
    clear_watchdog_instruction && !halt |=> !r.pdown) else $error("powerdown not cleared");
  rfc_zero_a: assert property (@(posedge mclk) disable iff (!reset_n)
    rd && wb_adr_i == ADR_RFC |=> wb_dat_o[6:1] == 6'h00) else $error("unimplemented bits nonzero");

  // bus side: one registered ack per request, data only beside it
  ack_pulse_a: assert property (@(posedge mclk) disable iff (!reset_n)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  ack_follow_a: assert property (@(posedge mclk) disable iff (!reset_n)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged");

  dat_idle_a: assert property (@(posedge mclk) disable iff (!reset_n)
    !wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");

  dat_upper_a: assert property (@(posedge mclk) disable iff (!reset_n)
    wb_dat_o[31:8] == 24'h0)
    else $error("upper read lanes not zero");

  mask_write_a: assert property (@(posedge mclk) disable iff (!reset_n)
    wr && wb_adr_i == ADR_IMK |=> r.imk == $past(wb_dat_i[1:0]))
    else $error("mask write lost");

  ist_clear_a: assert property (@(posedge mclk) disable iff (!reset_n)
    rd && wb_adr_i == ADR_IST && !ovf && r.st != KWD_FIRE |=> r.ist == 2'b00)
    else $error("status not cleared by read");

  irq_match_a: assert property (@(posedge mclk) disable iff (!reset_n)
    irq == |(r.ist & r.imk))
    else $error("interrupt level wrong");

  // reset requests are single pulses and never both at once
  rst_pulse_a: assert property (@(posedge mclk) disable iff (!reset_n)
    dev_reset |=> !dev_reset)
    else $error("device reset longer than one cycle");

  pcsp_pulse_a: assert property (@(posedge mclk) disable iff (!reset_n)
    pc_sp_reset |=> !pc_sp_reset)
    else $error("pc reset longer than one cycle");

  rst_excl_a: assert property (@(posedge mclk) disable iff (!reset_n)
    !(dev_reset && pc_sp_reset))
    else $error("both reset kinds at once");

  port_const_a: assert property (@(posedge mclk) disable iff (!reset_n)
    port_init == PORT_RESET)
    else $error("port init value changed");

  // counter behaviour
  count_step_a: assert property (@(posedge mclk) disable iff (!reset_n)
    en && tk.tick && !ovf && !clear_watchdog_instruction && !halt && !deep_sleep && r.st == KWD_RUN
    |=> r.cnt == $past(r.cnt) + 1)
    else $error("count did not step");

  frozen_a: assert property (@(posedge mclk) disable iff (!reset_n)
    key == KEY_DISABLE && !clear_watchdog_instruction && !halt && !deep_sleep && r.st == KWD_RUN |=> $stable(r.cnt))
    else $error("count moved while disabled");

  deep_stop_a: assert property (@(posedge mclk) disable iff (!reset_n)
    deep_sleep |-> !ovf)
    else $error("overflow in deepest sleep");

  tick_single_a: assert property (@(posedge mclk) disable iff (!reset_n)
    tk.tick |=> !tk.tick)
    else $error("source tick wider than one cycle");

  // key fault sequence
  fault_enter_a: assert property (@(posedge mclk) disable iff (!reset_n)
    r.st == KWD_RUN && key != KEY_ENABLE && key != KEY_DISABLE
    |=> r.st == KWD_WAIT && r.dly == 8'(FAULT_DELAY_CYC - 1))
    else $error("fault wait not entered");

  wait_count_a: assert property (@(posedge mclk) disable iff (!reset_n)
    r.st == KWD_WAIT |=> r.cnt == '0)
    else $error("count not cleared by key fault");

  dly_range_a: assert property (@(posedge mclk) disable iff (!reset_n)
    r.st == KWD_WAIT |-> r.dly < 8'(FAULT_DELAY_CYC))
    else $error("fault delay out of range");

  fire_flag_a: assert property (@(posedge mclk) disable iff (!reset_n)
    r.st == KWD_FIRE |=> r.key_flag && r.wdc == WDC_RESET && r.st == KWD_RUN)
    else $error("fault did not set flag and reload key");

  // status flags
  halt_flags_a: assert property (@(posedge mclk) disable iff (!reset_n)
    halt && !ovf && !clear_watchdog_instruction |=> r.pdown && !r.timeout)
    else $error("halt flags wrong");

  timeout_hold_a: assert property (@(posedge mclk) disable iff (!reset_n)
    r.timeout && !halt |=> r.timeout)
    else $error("timeout flag lost");
endmodule

// >>> tb/kwd_top_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin fails++; $display("Error %s exp %h got %h", nm, e, s); end end
module kwd_top_tb;
  import kwd_pkg::*;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic clear_watchdog_instruction = 1'b0, halt = 1'b0, sleep_mode = 1'b0, deep_sleep = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, dev_reset, pc_sp_reset, irq;
  logic [7:0] port_init, q;
  logic [1:0] rc_div = 2'h0;
  int fails = 0, n_checks = 0, cycles = 0, n_rst = 0, c, r0, lim;
  int seed = 32'h565ff28b;
  kwd_top u_dut (.mclk(mclk), .reset_n(reset_n), .rc_clk(rc_div[1]), .clear_watchdog_instruction(clear_watchdog_instruction), .halt(halt),
    .sleep_mode(sleep_mode), .deep_sleep(deep_sleep), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .dev_reset(dev_reset), .pc_sp_reset(pc_sp_reset),
    .port_init(port_init), .irq(irq));
  always #5 mclk = ~mclk;
  // rc source runs at a quarter of mclk so an overflow stays within a short run
  always @(posedge mclk) begin
    rc_div <= rc_div + 2'h1;
    cycles <= cycles + 1;
    if (dev_reset === 1'b1)
      n_rst <= n_rst + 1;
    if (cycles == 50000) begin
      fails++;
      close_out;
    end
  end
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic bus(input logic we, input logic [7:0] a, input logic [7:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'h1;
    wb_dat_i <= {24'h0, d};
    do begin
      @(posedge mclk);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic pulse_clr;
    clear_watchdog_instruction <= 1'b1;
    @(posedge mclk);
    clear_watchdog_instruction <= 1'b0;
  endtask
  task automatic wait_pulse(input bit pc);
    c = 0;
    do begin
      @(posedge mclk);
      c++;
    end while ((pc ? pc_sp_reset : dev_reset) !== 1'b1 && c < 20000);
  endtask
  initial begin
    repeat (2) @(posedge mclk);
    `CHK("rst_req", 1'b1, dev_reset)
    `CHK("ports", 8'hff, port_init)
    reset_n <= 1'b1;
    @(posedge mclk);
    bus(1'b0, ADR_WDC, 8'h00);
    `CHK("wdc_por", WDC_RESET, q)
    bus(1'b1, ADR_RFC, 8'hff);
    bus(1'b0, ADR_RFC, 8'h00);
    `CHK("rfc", 8'h80, q)
    bus(1'b1, ADR_RFC, 8'h00);
    bus(1'b1, 8'h14, 8'($random(seed)));
    bus(1'b0, 8'h14, 8'h00);
    `CHK("unmapped", 8'h00, q)
    bus(1'b1, ADR_IMK, 8'h03);
    for (int s = 0; s < 3; s++) begin
      bus(1'b1, ADR_WDC, {KEY_ENABLE, 3'(s)});
      pulse_clr;
      wait_pulse(1'b0);
      lim = 1 << (10 + 2 * s);
      `CHK("ovf_time", 1'b1, c > lim - 8 && c < lim + 8)
      repeat (2) @(posedge mclk);
      `CHK("irq_on", 1'b1, irq)
      bus(1'b0, ADR_CST, 8'h00);
      `CHK("timeout", 1'b1, q[ST_TIMEOUT])
      bus(1'b0, ADR_IST, 8'h00);
      `CHK("ist", 8'h01, q)
      bus(1'b0, ADR_IST, 8'h00);
      `CHK("ist_clr", 8'h00, q)
      @(posedge mclk);
      `CHK("irq_off", 1'b0, irq)
    end
    // clears come just inside the shortest timeout, at random spacing
    bus(1'b1, ADR_WDC, 8'h50);
    r0 = n_rst;
    repeat (6) begin
      pulse_clr;
      repeat (700 + 8'($random(seed))) @(posedge mclk);
    end
    `CHK("kept_alive", r0, n_rst)
    halt <= 1'b1;
    @(posedge mclk);
    halt <= 1'b0;
    bus(1'b0, ADR_CST, 8'h00);
    `CHK("halt_st", 8'h02, q)
    pulse_clr;
    bus(1'b0, ADR_CST, 8'h00);
    `CHK("clr_st", 8'h00, q)
    sleep_mode <= 1'b1;
    pulse_clr;
    r0 = n_rst;
    wait_pulse(1'b1);
    `CHK("slp_time", 1'b1, c > 1016 && c < 1032)
    `CHK("slp_nofull", r0, n_rst)
    sleep_mode <= 1'b0;
    bus(1'b0, ADR_CST, 8'h00);
    `CHK("slp_st", 8'h01, q)
    bus(1'b0, ADR_IST, 8'h00);
    bus(1'b1, ADR_WDC, {KEY_DISABLE, 3'h0});
    r0 = n_rst;
    repeat (1500) @(posedge mclk);
    `CHK("disabled", r0, n_rst)
    bus(1'b1, ADR_WDC, 8'h50);
    deep_sleep <= 1'b1;
    repeat (1500) @(posedge mclk);
    deep_sleep <= 1'b0;
    `CHK("deep", r0, n_rst)
    bus(1'b1, ADR_WDC, 8'h00);
    wait_pulse(1'b0);
    `CHK("fault_dly", 1'b1, c > 12 && c < 19)
    bus(1'b0, ADR_RFC, 8'h00);
    `CHK("flag", 8'h01, q)
    bus(1'b0, ADR_WDC, 8'h00);
    `CHK("reload", WDC_RESET, q)
    bus(1'b0, ADR_IST, 8'h00);
    `CHK("ist_key", 8'h02, q)
    bus(1'b1, ADR_RFC, 8'h00);
    bus(1'b0, ADR_RFC, 8'h00);
    `CHK("flag_clr", 8'h00, q)
    close_out;
  end
endmodule
